// [pkg/match_unit_cfg.svh]
// Register indices, field positions, reset values and mode codes of the capture/compare unit.
`ifndef MATCH_UNIT_CFG_SVH
`define MATCH_UNIT_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_PORT_DATA 10'h007
`define IDX_IRQ_FLAGS 10'h00c
`define IDX_TIMER_LOW 10'h00e
`define IDX_TIMER_HIGH 10'h00f
`define IDX_TIMER_CTRL 10'h010
`define IDX_PWM_BASE 10'h011
`define IDX_MATCH_LOW 10'h015
`define IDX_MATCH_HIGH 10'h016
`define IDX_UNIT_CTRL 10'h017
`define IDX_PORT_DIR 10'h087
`define IDX_IRQ_ENABLES 10'h08c
`define IDX_PWM_PERIOD 10'h092

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define FLAG_UNIT_BIT 2
`define FLAG_TIMER_BIT 0
`define FLAGS_MASK 8'h05
`define TIMER_ON_BIT 0
`define TIMER_CTRL_MASK 8'h3f
`define PIN_BIT 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_FLAGS 8'h00
`define RST_ENABLES 8'h00
`define RST_TIMER_CTRL 8'h00
`define RST_UNIT_CTRL 4'h0
`define RST_PORT_DIR 8'hff
`define RST_PWM_PERIOD 8'hff

// ----------------------------------------------------------------------------
// Mode field codes
// ----------------------------------------------------------------------------
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_TRIGGER 4'hb

// ----------------------------------------------------------------------------
// Prescaler terminal counts
// ----------------------------------------------------------------------------
`define PRESCALE_LAST4 4'h3
`define PRESCALE_LAST16 4'hf

`endif

// [pkg/match_unit_pkg.sv]
// Types shared by the capture/compare unit and its edge prescaler.
package match_unit_pkg;
  `include "match_unit_cfg.svh"

  typedef enum logic [3:0] {
    mode_off_type = `MODE_OFF,
    mode_cap_fall_type = `MODE_CAP_FALL,
    mode_cap_rise_type = `MODE_CAP_RISE,
    mode_cap_rise4_type = `MODE_CAP_RISE4,
    mode_cap_rise16_type = `MODE_CAP_RISE16,
    mode_cmp_set_type = `MODE_CMP_SET,
    mode_cmp_clear_type = `MODE_CMP_CLEAR,
    mode_cmp_soft_type = `MODE_CMP_SOFT,
    mode_cmp_trigger_type = `MODE_CMP_TRIGGER
  } unit_mode_type;

  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic level_prev;
    logic [3:0] count;
    logic event_out;
  } prescale_state_type;

  typedef struct packed {
    logic [15:0] timer;
    logic [15:0] match_value;
    logic [1:0] duty_lsb;
    logic [3:0] unit_mode_field;
    logic [7:0] timer_control;
    logic [7:0] irq_flags;
    logic [7:0] irq_enables;
    logic [7:0] port_direction;
    logic [7:0] port_data;
    logic [7:0] pwm_period;
    logic [7:0] pwm_base;
    logic [1:0] pwm_sub;
    logic [1:0] duty_latch;
    logic out_latch;
    logic match_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adc_start;
    logic pin_out;
    logic pin_oe_n;
    logic irq_request;
  } unit_state_type;
endpackage

// [rtl/edge_prescaler.sv]
// Pin synchroniser, edge detector and capture event prescaler.
`timescale 1ns/100ps
module edge_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  input wire logic [3:0] mode,
  output logic event_out
);
  import match_unit_pkg::*;

  prescale_state_type s_q;
  prescale_state_type s_d;
  logic capture_on;
  logic edge_seen;

  assign event_out = s_q.event_out;

  always_comb begin
    s_d = s_q;
    // The timer is sampled only from a settled pin level.
    s_d.sync_first = pin_in;
    s_d.sync_second = s_q.sync_first;
    s_d.level_prev = s_q.sync_second;
    s_d.event_out = 1'b0;
    capture_on = (mode[3:2] == 2'b01);
    if (mode == `MODE_CAP_FALL) begin
      edge_seen = s_q.level_prev & ~s_q.sync_second;
    end else begin
      edge_seen = ~s_q.level_prev & s_q.sync_second;
    end
    if (!capture_on) begin
      // Off or not capturing: the counter is held clear.
      s_d.count = 4'h0;
    end else if (edge_seen) begin
      // Moving between prescale settings keeps the count.
      s_d.count = s_q.count + 4'h1;
      case (mode)
        `MODE_CAP_RISE4: begin
          s_d.event_out = (s_q.count[1:0] == 2'(`PRESCALE_LAST4));
        end
        `MODE_CAP_RISE16: begin
          s_d.event_out = (s_q.count == `PRESCALE_LAST16);
        end
        default: begin
          s_d.event_out = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// [rtl/capture_compare_unit.sv]
// Capture/compare/PWM unit with its 16-bit timer, pin mux and APB register file.
`timescale 1ns/100ps
module capture_compare_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic unit_pin_in,
  output logic unit_pin_out,
  output logic unit_pin_oe_n,
  input wire logic adc_enabled,
  output logic adc_start,
  output logic irq_request
);
  import match_unit_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  unit_state_type s_q;
  unit_state_type s_d;
  logic capture_event;
  logic [9:0] index;
  logic access_first;
  logic write_take;
  logic is_capture;
  logic is_compare;
  logic is_pwm;
  logic timer_on;
  logic timer_equal;
  logic compare_hit;
  logic trigger_hit;
  logic overflow_hit;
  logic unit_flag_set;
  logic [9:0] pwm_count;
  logic [9:0] duty_active;
  logic [7:0] read_byte;
  logic mapped;

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign unit_pin_out = s_q.pin_out;
  assign unit_pin_oe_n = s_q.pin_oe_n;
  assign adc_start = s_q.adc_start;
  assign irq_request = s_q.irq_request;

  // --------------------------------------------------------------------------
  // Capture edge path
  // --------------------------------------------------------------------------
  // The pin is read back even while the unit drives it, so a port write that
  // toggles a driven pin is seen as an edge.
  // The prescaler keeps its own count, so only the mode is handed to it.
  edge_prescaler prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(unit_pin_in),
    .mode(s_q.unit_mode_field),
    .event_out(capture_event)
  );

  // --------------------------------------------------------------------------
  // Register read mux
  // --------------------------------------------------------------------------
  // Unmapped indices answer with an error and read as zero; writes to them are dropped.
  always_comb begin
    read_byte = 8'h00;
    mapped = 1'b1;
    case (index)
      `IDX_PORT_DATA: begin
        read_byte = s_q.port_data;
      end
      `IDX_IRQ_FLAGS: begin
        read_byte = s_q.irq_flags & `FLAGS_MASK;
      end
      `IDX_TIMER_LOW: begin
        read_byte = s_q.timer[7:0];
      end
      `IDX_TIMER_HIGH: begin
        read_byte = s_q.timer[15:8];
      end
      `IDX_TIMER_CTRL: begin
        read_byte = s_q.timer_control & `TIMER_CTRL_MASK;
      end
      `IDX_PWM_BASE: begin
        read_byte = s_q.pwm_base;
      end
      `IDX_MATCH_LOW: begin
        read_byte = s_q.match_value[7:0];
      end
      `IDX_MATCH_HIGH: begin
        read_byte = s_q.match_value[15:8];
      end
      `IDX_UNIT_CTRL: begin
        read_byte = {2'b00, s_q.duty_lsb, s_q.unit_mode_field};
      end
      `IDX_PORT_DIR: begin
        read_byte = s_q.port_direction;
      end
      `IDX_IRQ_ENABLES: begin
        read_byte = s_q.irq_enables & `FLAGS_MASK;
      end
      `IDX_PWM_PERIOD: begin
        read_byte = s_q.pwm_period;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    index = paddr[11:2];
    // Every access waits one cycle; the answer is prepared while pready is low.
    access_first = psel & penable & ~s_q.pready;
    write_take = psel & penable & pwrite & s_q.pready;
    is_capture = (s_q.unit_mode_field[3:2] == 2'b01);
    is_compare = (s_q.unit_mode_field[3:2] == 2'b10);
    is_pwm = (s_q.unit_mode_field[3:2] == 2'b11);
    timer_on = s_q.timer_control[`TIMER_ON_BIT];
    pwm_count = {s_q.pwm_base, s_q.pwm_sub};
    duty_active = {s_q.match_value[15:8], s_q.duty_latch};
    unit_flag_set = 1'b0;

    // ------------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------------
    // Read data is taken in the first access cycle and then held until the
    // next access starts, so the master may sample it late.
    s_d.pready = access_first;
    s_d.pslverr = access_first & ~mapped;
    s_d.adc_start = 1'b0;
    if (access_first) begin
      s_d.prdata = {24'h000000, read_byte};
    end

    // ------------------------------------------------------------------------
    // Compare and timer
    // ------------------------------------------------------------------------
    // Compare is checked every cycle; one hit per arrival at equality.
    timer_equal = (s_q.timer == s_q.match_value);
    compare_hit = is_compare & timer_equal & ~s_q.match_prev;
    s_d.match_prev = is_compare & timer_equal;
    trigger_hit = compare_hit & (s_q.unit_mode_field == `MODE_CMP_TRIGGER);

    // The timer counts pclk whenever its run bit is set. Clock-source and
    // prescale bits are stored only, so the unsynchronised counter mode in
    // which capture and compare would be unreliable can never be entered.
    // Timer: a trigger reset takes the place of the increment and raises no
    // overflow.
    overflow_hit = 1'b0;
    if (trigger_hit) begin
      s_d.timer = 16'h0000;
    end else if (timer_on) begin
      s_d.timer = s_q.timer + 16'h0001;
      overflow_hit = (s_q.timer == 16'hffff);
    end
    if (trigger_hit & adc_enabled) begin
      s_d.adc_start = 1'b1;
    end

    if (compare_hit) begin
      unit_flag_set = 1'b1;
      case (s_q.unit_mode_field)
        `MODE_CMP_SET: begin
          s_d.out_latch = 1'b1;
        end
        `MODE_CMP_CLEAR: begin
          s_d.out_latch = 1'b0;
        end
        default: begin
          // Software-interrupt and trigger modes leave the pin alone.
          s_d.out_latch = s_q.out_latch;
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------------
    // Capture copies the running timer; a second capture simply overwrites.
    if (is_capture & capture_event) begin
      s_d.match_value = s_q.timer;
      unit_flag_set = 1'b1;
    end

    // ------------------------------------------------------------------------
    // PWM time base
    // ------------------------------------------------------------------------
    // PWM: 10-bit count of base and sub-cycle against the latched duty.
    if (is_pwm) begin
      if (pwm_count == {s_q.pwm_period, 2'b11}) begin
        s_d.pwm_base = 8'h00;
        s_d.pwm_sub = 2'b00;
        s_d.match_value[15:8] = s_q.match_value[7:0];
        s_d.duty_latch = s_q.duty_lsb;
        s_d.out_latch = ({s_q.match_value[7:0], s_q.duty_lsb} != 10'h000);
      end else begin
        {s_d.pwm_base, s_d.pwm_sub} = pwm_count + 10'h001;
        if (pwm_count == duty_active) begin
          s_d.out_latch = 1'b0;
        end
      end
    end else begin
      s_d.pwm_base = 8'h00;
      s_d.pwm_sub = 2'b00;
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Software writes take effect at the edge that completes the transfer.
    if (write_take) begin
      case (index)
        `IDX_PORT_DATA: begin
          s_d.port_data = pwdata[7:0];
        end
        `IDX_IRQ_FLAGS: begin
          s_d.irq_flags = pwdata[7:0] & `FLAGS_MASK;
        end
        `IDX_TIMER_LOW: begin
          s_d.timer[7:0] = pwdata[7:0];
        end
        `IDX_TIMER_HIGH: begin
          s_d.timer[15:8] = pwdata[7:0];
        end
        `IDX_TIMER_CTRL: begin
          s_d.timer_control = pwdata[7:0] & `TIMER_CTRL_MASK;
        end
        `IDX_MATCH_LOW: begin
          s_d.match_value[7:0] = pwdata[7:0];
        end
        `IDX_MATCH_HIGH: begin
          // In PWM mode the high byte holds the latched duty and is read-only.
          if (!is_pwm) begin
            s_d.match_value[15:8] = pwdata[7:0];
          end
        end
        `IDX_UNIT_CTRL: begin
          s_d.unit_mode_field = pwdata[3:0];
          s_d.duty_lsb = pwdata[5:4];
          // Moving between two capture settings raises a false flag; going
          // through off first avoids it.
          if (is_capture && pwdata[3:2] == 2'b01 && pwdata[3:0] != s_q.unit_mode_field) begin
            unit_flag_set = 1'b1;
          end
        end
        `IDX_PORT_DIR: begin
          s_d.port_direction = pwdata[7:0];
        end
        `IDX_IRQ_ENABLES: begin
          s_d.irq_enables = pwdata[7:0] & `FLAGS_MASK;
        end
        `IDX_PWM_PERIOD: begin
          s_d.pwm_period = pwdata[7:0];
        end
        default: begin
          s_d.port_data = s_d.port_data;
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Latch, flags and pin
    // ------------------------------------------------------------------------
    // Off clears the output latch; the pin then shows the port data bit.
    if (s_d.unit_mode_field == `MODE_OFF) begin
      s_d.out_latch = 1'b0;
    end

    // Hardware sets are applied last so they beat a clear in the same cycle.
    if (unit_flag_set) begin
      s_d.irq_flags[`FLAG_UNIT_BIT] = 1'b1;
    end
    if (overflow_hit) begin
      s_d.irq_flags[`FLAG_TIMER_BIT] = 1'b1;
    end

    // The unit owns the pin in compare and PWM modes; otherwise the port
    // latch shows through. Direction stays with software.
    if (s_d.unit_mode_field[3]) begin
      s_d.pin_out = s_d.out_latch;
    end else begin
      s_d.pin_out = s_d.port_data[`PIN_BIT];
    end
    s_d.pin_oe_n = s_d.port_direction[`PIN_BIT];
    // A match or capture reaches the request line only when enabled.
    s_d.irq_request = |(s_d.irq_flags & s_d.irq_enables & `FLAGS_MASK);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.irq_flags <= `RST_FLAGS;
      s_q.irq_enables <= `RST_ENABLES;
      s_q.timer_control <= `RST_TIMER_CTRL;
      s_q.unit_mode_field <= `RST_UNIT_CTRL;
      s_q.port_direction <= `RST_PORT_DIR;
      s_q.pwm_period <= `RST_PWM_PERIOD;
      s_q.pin_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// [bench/capture_compare_unit_assertions.sv]
// Port-level concurrent checks for the capture/compare unit.
`timescale 1ns/100ps
module capture_compare_unit_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic unit_pin_in,
  input wire logic unit_pin_out,
  input wire logic unit_pin_oe_n,
  input wire logic adc_enabled,
  input wire logic adc_start,
  input wire logic irq_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_done;
  logic mapped;
  logic zero_wr;
  logic port_bit_q;
  assign wr_done = psel && penable && pready && pwrite;
  assign zero_wr = wr_done && paddr[11:2] == 10'h017 && pwdata[3:0] == 4'h0;
  // With the unit off the pin shows the port data bit, so that bit is tracked here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_bit_q <= 1'b0;
    end else if (wr_done && paddr[11:2] == 10'h007) begin
      port_bit_q <= pwdata[2];
    end
  end
  always_comb begin
    case (paddr[11:2])
      10'h007, 10'h00c, 10'h00e, 10'h00f, 10'h010, 10'h011, 10'h015, 10'h016, 10'h017, 10'h087, 10'h08c,
      10'h092: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("ready did not follow the first access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_error_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match the address map");
  a_data_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data has upper bits set");
  // --------------------------------------------------------------------------
  // Pin and trigger
  // --------------------------------------------------------------------------
  a_zero_clears_latch: assert property (zero_wr |=> unit_pin_out == port_bit_q)
    else $error("output latch not cleared by unit off write");
  a_dir_by_write: assert property ($changed(unit_pin_oe_n) |-> $past(wr_done))
    else $error("pin direction changed without a register write");
  a_start_single: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  a_start_gated: assert property (adc_start |-> $past(adc_enabled))
    else $error("conversion started while converter disabled");
endmodule
bind capture_compare_unit capture_compare_unit_assertions capture_compare_unit_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .unit_pin_in(unit_pin_in),
  .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n), .adc_enabled(adc_enabled),
  .adc_start(adc_start), .irq_request(irq_request)
);

// [bench/pin_source_model.sv]
// External signal source and load on the unit pin, resolving the wire level.
`timescale 1ns/100ps
module pin_source_model (
  input wire logic src_level,
  input wire logic unit_pin_out,
  input wire logic unit_pin_oe_n,
  output logic pin_wire
);
  // The source backs off while the unit drives, so the unit then sees its own level.
  assign pin_wire = unit_pin_oe_n ? src_level : unit_pin_out;
endmodule

// [bench/testbench.sv]
// Self-checking bench for the capture/compare unit.
`timescale 1ns/100ps
`include "match_unit_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, adc_enabled = 0, src_level = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr, unit_pin_out, unit_pin_oe_n, adc_start, irq_request, pin_wire, er;
  logic [7:0] rd;
  logic [15:0] v, m;
  int err_count = 0, checks_done = 0, cycles = 0, starts = 0, seed = 91;
  int idxq[$] = '{'h0c, 'h8c, 'h10, 'h17, 'h87};
  int rstq[$] = '{0, 0, 0, 0, 'hff};
  int modeq[$] = '{'h0, 'h4, 'h5, 'h6, 'h7, 'h8, 'h9, 'ha, 'hb, 'hc};
  int cmpq[$] = '{'h8, 'h9, 'h8, 'ha};
  int pinq[$] = '{1, 0, 1, 1};
  int enq[$] = '{0, 0, 0, 4};
  capture_compare_unit capture_compare_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_pin_in(pin_wire), .unit_pin_out(unit_pin_out),
    .unit_pin_oe_n(unit_pin_oe_n), .adc_enabled(adc_enabled), .adc_start(adc_start),
    .irq_request(irq_request));
  pin_source_model pin_source_model_i (.src_level(src_level), .unit_pin_out(unit_pin_out),
    .unit_pin_oe_n(unit_pin_oe_n), .pin_wire(pin_wire));
  always #25 pclk = ~pclk;
  // --------------------------------------------------------------------------
  // Watchdog and trigger pulse counter
  // --------------------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (adc_start === 1'b1) starts++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Request stays put until ready is sampled high, so slow answers are tolerated.
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHK(rd, e)
  endtask
  task automatic set_timer(input logic [15:0] t);
    wr(`IDX_TIMER_LOW, t[7:0]);
    wr(`IDX_TIMER_HIGH, t[15:8]);
  endtask
  task automatic edge_to(input logic l);
    @(posedge pclk);
    src_level <= l;
    repeat (8) @(posedge pclk);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      edge_to(1'b1);
      edge_to(1'b0);
    end
  endtask
  task automatic fresh(input logic [3:0] md);
    wr(`IDX_UNIT_CTRL, 8'h00);
    wr(`IDX_UNIT_CTRL, {4'h0, md});
    wr(`IDX_IRQ_FLAGS, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idxq[i]) rdchk(idxq[i], rstq[i]);
    xfer(1'b0, 10'h020, 8'h00);
    `CHK(er, 1'b1)
    foreach (modeq[i]) begin
      wr(`IDX_UNIT_CTRL, 8'h30 | modeq[i]);
      rdchk(`IDX_UNIT_CTRL, 8'h30 | modeq[i]);
    end
    $display("test registers ends");
    v = $random(seed);
    fresh(`MODE_CAP_RISE);
    for (int i = 0; i < 2; i++) begin
      set_timer(v ^ {16{i[0]}});
      pulses(1);
      rdchk(`IDX_MATCH_LOW, v[7:0] ^ {8{i[0]}});
      rdchk(`IDX_MATCH_HIGH, v[15:8] ^ {8{i[0]}});
      rdchk(`IDX_IRQ_FLAGS, 8'h04);
    end
    fresh(`MODE_CAP_FALL);
    edge_to(1'b1);
    rdchk(`IDX_IRQ_FLAGS, 8'h00);
    edge_to(1'b0);
    rdchk(`IDX_IRQ_FLAGS, 8'h04);
    for (int k = 4; k <= 16; k += 12) begin
      fresh(k == 4 ? `MODE_CAP_RISE4 : `MODE_CAP_RISE16);
      pulses(k - 1);
      rdchk(`IDX_IRQ_FLAGS, 8'h00);
      pulses(1);
      rdchk(`IDX_IRQ_FLAGS, 8'h04);
    end
    fresh(`MODE_CAP_RISE4);
    pulses(2);
    wr(`IDX_UNIT_CTRL, {4'h0, `MODE_CAP_RISE16});
    rdchk(`IDX_IRQ_FLAGS, 8'h04);
    wr(`IDX_IRQ_FLAGS, 8'h00);
    pulses(13);
    rdchk(`IDX_IRQ_FLAGS, 8'h00);
    pulses(1);
    rdchk(`IDX_IRQ_FLAGS, 8'h04);
    $display("test capture ends");
    wr(`IDX_PORT_DIR, 8'hfb);
    fresh(`MODE_CAP_RISE);
    wr(`IDX_PORT_DATA, 8'h04);
    repeat (8) @(posedge pclk);
    rdchk(`IDX_IRQ_FLAGS, 8'h04);
    `CHK(unit_pin_oe_n, 1'b0)
    wr(`IDX_PORT_DATA, 8'h00);
    wr(`IDX_UNIT_CTRL, 8'h00);
    m = {v[15:8] | 8'h10, 8'h80};
    foreach (cmpq[i]) begin
      wr(`IDX_TIMER_CTRL, 8'h00);
      set_timer(m - 16'h4);
      wr(`IDX_UNIT_CTRL, cmpq[i]);
      wr(`IDX_MATCH_LOW, m[7:0]);
      wr(`IDX_MATCH_HIGH, m[15:8]);
      wr(`IDX_IRQ_ENABLES, enq[i]);
      wr(`IDX_IRQ_FLAGS, 8'h00);
      wr(`IDX_TIMER_CTRL, 8'h01);
      repeat (12) @(posedge pclk);
      `CHK(unit_pin_out, pinq[i][0])
      `CHK(irq_request, enq[i] != 0)
      rdchk(`IDX_IRQ_FLAGS, 8'h04);
    end
    wr(`IDX_UNIT_CTRL, 8'h00);
    @(posedge pclk);
    `CHK(unit_pin_out, 1'b0)
    $display("test compare ends");
    for (int j = 0; j < 2; j++) begin
      wr(`IDX_TIMER_CTRL, 8'h00);
      set_timer(m - 16'h4);
      adc_enabled <= j[0] ^ v[0];
      wr(`IDX_UNIT_CTRL, {4'h0, `MODE_CMP_TRIGGER});
      wr(`IDX_IRQ_FLAGS, 8'h00);
      starts = 0;
      wr(`IDX_TIMER_CTRL, 8'h01);
      repeat (12) @(posedge pclk);
      wr(`IDX_TIMER_CTRL, 8'h00);
      `CHK(starts, (j[0] ^ v[0]) ? 1 : 0)
      rdchk(`IDX_TIMER_HIGH, 8'h00);
      rdchk(`IDX_IRQ_FLAGS, 8'h04);
    end
    wr(`IDX_UNIT_CTRL, 8'h00);
    set_timer(16'hfff8);
    wr(`IDX_IRQ_FLAGS, 8'h00);
    wr(`IDX_TIMER_CTRL, 8'h01);
    repeat (12) @(posedge pclk);
    wr(`IDX_TIMER_CTRL, 8'h00);
    rdchk(`IDX_IRQ_FLAGS, 8'h01);
    $display("test trigger ends");
    // A duty longer than the period keeps the output high after the first period end.
    wr(`IDX_PWM_PERIOD, 8'h01);
    wr(`IDX_MATCH_LOW, 8'hff);
    wr(`IDX_UNIT_CTRL, 8'h0c);
    repeat (20) @(posedge pclk);
    `CHK(unit_pin_out, 1'b1)
    wr(`IDX_UNIT_CTRL, 8'h00);
    @(posedge pclk);
    `CHK(unit_pin_out, 1'b0)
    $display("test pwm ends");
    final_report();
  end
endmodule
